// ==== logic/mgmt_device.sv ====
// device end: frame decoder and management register file
`timescale 1ns/10ps
`default_nettype none
module mgmt_device (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  mgmt_if.device           link,
  input  wire logic [15:0] status_i,
  output logic      [15:0] basic_control_o,
  output logic      [15:0] extended_control_o,
  output logic             preamble_skip_o,
  output logic             write_strobe_o,
  output logic      [4:0]  write_addr_o,
  output logic      [15:0] write_data_o
);

  typedef enum logic [2:0] {
    ST_PREAMBLE = 3'h0,
    ST_START    = 3'h1,
    ST_OPCODE   = 3'h2,
    ST_ADDRESS  = 3'h3,
    ST_TURN     = 3'h4,
    ST_DATA     = 3'h5
  } state_t;

  typedef struct packed {
    logic               mdc_s1;
    logic               mdc_s2;
    logic               mdc_s3;
    logic               io_s1;
    logic               io_s2;
    state_t             state;
    logic [5:0]         ones;
    logic [3:0]         cnt;
    logic [1:0]         op;
    logic [9:0]         addr_sh;
    logic [15:0]        in_sh;
    logic [15:0]        out_sh;
    logic               is_read;
    logic               is_write;
    logic               unlock;
    logic               mdio_o;
    logic               mdio_oe;
    logic               wr_stb;
    logic [4:0]         wr_addr;
    logic [15:0]        wr_data;
    logic [31:0][15:0]  regs;
  } dev_state_t;

  dev_state_t q;
  dev_state_t d;

  logic        rise;
  logic        bit_in;
  logic        skip;
  logic [4:0]  station;
  logic [4:0]  frame_station;
  logic [4:0]  frame_reg;
  logic        match;
  logic [15:0] read_word;
  logic [15:0] allow;

  assign rise          = q.mdc_s2 & ~q.mdc_s3;
  assign bit_in        = q.io_s2;
  assign skip          = q.regs[mgmt_pkg::REG_BASIC_STATUS]
                               [mgmt_pkg::SKIP_BIT];
  assign station       = q.regs[mgmt_pkg::REG_EXTENDED_CONTROL]
                               [mgmt_pkg::STATION_MSB:mgmt_pkg::STATION_LSB];
  assign frame_station = q.addr_sh[8:4];
  assign frame_reg     = {q.addr_sh[3:0], bit_in};
  assign match         = (frame_station == station);

  always_comb begin
    if (!mgmt_pkg::is_present(frame_reg)) begin
      read_word = mgmt_pkg::ABSENT_VALUE;
    end else if (frame_reg == mgmt_pkg::REG_BASIC_STATUS) begin
      read_word = (status_i & ~mgmt_pkg::gated_mask(frame_reg)) |
                  (q.regs[frame_reg] & mgmt_pkg::gated_mask(frame_reg));
    end else begin
      read_word = q.regs[frame_reg];
    end
  end

  always_comb begin
    allow = mgmt_pkg::plain_mask(q.wr_addr);
    if (q.unlock) begin
      allow = allow | mgmt_pkg::gated_mask(q.wr_addr);
    end
  end

  always_comb begin
    d        = q;
    d.mdc_s1 = link.mdc;
    d.mdc_s2 = q.mdc_s1;
    d.mdc_s3 = q.mdc_s2;
    d.io_s1  = link.mdio;
    d.io_s2  = q.io_s1;
    d.wr_stb = 1'b0;

    if (rise) begin
      unique case (q.state)
        ST_PREAMBLE: begin
          if (bit_in) begin
            if (q.ones != mgmt_pkg::PREAMBLE_LEN) begin
              d.ones = q.ones + 6'h01;
            end
          end else begin
            d.ones = 6'h00;
            if (q.ones == mgmt_pkg::PREAMBLE_LEN || skip) begin
              d.state = ST_START;
            end
          end
        end
        ST_START: begin
          if (bit_in == mgmt_pkg::START_CODE[0]) begin
            d.state = ST_OPCODE;
            d.cnt   = 4'h0;
          end else if (!skip) begin
            d.state = ST_PREAMBLE;
          end
        end
        ST_OPCODE: begin
          d.op  = {q.op[0], bit_in};
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'h1) begin
            d.state = ST_ADDRESS;
            d.cnt   = 4'h0;
          end
        end
        ST_ADDRESS: begin
          d.addr_sh = {q.addr_sh[8:0], bit_in};
          d.cnt     = q.cnt + 4'h1;
          if (q.cnt == mgmt_pkg::ADDR_BITS_LAST) begin
            d.state    = ST_TURN;
            d.cnt      = 4'h0;
            d.wr_addr  = frame_reg;
            d.is_read  = match && (q.op == mgmt_pkg::OP_READ);
            d.is_write = match && (q.op == mgmt_pkg::OP_WRITE);
            d.out_sh   = read_word;
          end
        end
        ST_TURN: begin
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'h0) begin
            d.mdio_oe = q.is_read;
            d.mdio_o  = 1'b0;
          end else begin
            d.state  = ST_DATA;
            d.cnt    = 4'h0;
            d.mdio_o = q.out_sh[15];
            d.out_sh = {q.out_sh[14:0], 1'b0};
          end
        end
        ST_DATA: begin
          d.in_sh  = {q.in_sh[14:0], bit_in};
          d.cnt    = q.cnt + 4'h1;
          d.mdio_o = q.out_sh[15];
          d.out_sh = {q.out_sh[14:0], 1'b0};
          if (q.cnt == mgmt_pkg::DATA_BITS_LAST) begin
            d.mdio_oe  = 1'b0;
            d.mdio_o   = 1'b0;
            d.state    = ST_PREAMBLE;
            d.ones     = 6'h00;
            d.is_read  = 1'b0;
            d.is_write = 1'b0;
            if (q.is_write) begin
              d.wr_data = {q.in_sh[14:0], bit_in};
              d.wr_stb  = mgmt_pkg::is_present(q.wr_addr);
            end
          end
        end
        default: begin
          d.state   = ST_PREAMBLE;
          d.mdio_oe = 1'b0;
        end
      endcase
    end

    if (q.wr_stb) begin
      d.regs[q.wr_addr] = (q.regs[q.wr_addr] & ~allow) |
                          (q.wr_data & allow);
      if (q.wr_addr != mgmt_pkg::REG_EXTENDED_CONTROL) begin
        d.unlock = 1'b0;
      end else begin
        d.unlock = q.wr_data[mgmt_pkg::UNLOCK_BIT];
        d.regs[q.wr_addr][mgmt_pkg::UNLOCK_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q          <= '0;
      q.state    <= ST_PREAMBLE;
      for (int i = 0; i < 32; i++) begin
        q.regs[i] <= mgmt_pkg::reset_value(5'(i));
      end
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign link.dev_mdio_o  = q.mdio_o;
  assign link.dev_mdio_oe = q.mdio_oe;
  assign basic_control_o    = q.regs[mgmt_pkg::REG_BASIC_CONTROL];
  assign extended_control_o = q.regs[mgmt_pkg::REG_EXTENDED_CONTROL];
  assign preamble_skip_o    = skip;
  assign write_strobe_o     = q.wr_stb;
  assign write_addr_o       = q.wr_addr;
  assign write_data_o       = q.wr_data;

endmodule
`default_nettype wire

// ==== logic/mgmt_host.sv ====
// controller end: makes the management clock and sends frames
`timescale 1ns/10ps
`default_nettype none
module mgmt_host (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  mgmt_if.host             link,
  input  wire logic        req_i,
  input  wire logic        req_write_i,
  input  wire logic        req_preamble_i,
  input  wire logic        req_bad_op_i,
  input  wire logic [4:0]  req_station_i,
  input  wire logic [4:0]  req_reg_i,
  input  wire logic [15:0] req_data_i,
  output logic             busy_o,
  output logic             done_o,
  output logic      [15:0] rd_data_o
);

  typedef enum logic [0:0] {
    HS_IDLE = 1'b0,
    HS_RUN  = 1'b1
  } hstate_t;

  typedef struct packed {
    logic        io_s1;
    logic        io_s2;
    hstate_t     state;
    logic [3:0]  div;
    logic [6:0]  bit_n;
    logic [63:0] frame;
    logic        is_read;
    logic        mdc;
    logic        mdio_o;
    logic        mdio_oe;
    logic [15:0] rd_sh;
    logic [15:0] rd_data;
    logic        done;
  } host_state_t;

  host_state_t q;
  host_state_t d;
  logic [6:0]  next_n;

  assign next_n = q.bit_n + 7'h01;

  always_comb begin
    d       = q;
    d.io_s1 = link.mdio;
    d.io_s2 = q.io_s1;
    d.done  = 1'b0;
    unique case (q.state)
      HS_IDLE: begin
        if (req_i) begin
          d.state   = HS_RUN;
          d.is_read = !req_write_i;
          d.frame   = {32'hFFFF_FFFF, mgmt_pkg::START_CODE,
                       req_bad_op_i ? {2{req_write_i}} :
                       req_write_i  ? mgmt_pkg::OP_WRITE
                                    : mgmt_pkg::OP_READ,
                       req_station_i, req_reg_i,
                       mgmt_pkg::TA_WRITE, req_data_i};
          d.bit_n   = req_preamble_i ? 7'h00
                                     : mgmt_pkg::NO_PRE_FIRST;
          d.div     = 4'h0;
          d.mdc     = 1'b0;
          d.mdio_oe = 1'b1;
          d.mdio_o  = req_preamble_i ? 1'b1 : mgmt_pkg::START_CODE[1];
        end
      end
      HS_RUN: begin
        d.div = q.div + 4'h1;
        if (q.div == mgmt_pkg::MDC_HALF - 4'h1) begin
          d.div = 4'h0;
          d.mdc = !q.mdc;
          if (!q.mdc) begin
            if (q.is_read && q.bit_n >= mgmt_pkg::DATA_FIRST) begin
              d.rd_sh = {q.rd_sh[14:0], q.io_s2};
            end
          end else if (q.bit_n == mgmt_pkg::FRAME_LAST) begin
            d.state   = HS_IDLE;
            d.mdio_oe = 1'b0;
            d.mdio_o  = 1'b0;
            d.rd_data = q.rd_sh;
            d.done    = 1'b1;
          end else begin
            d.bit_n   = next_n;
            d.mdio_o  = q.frame[6'(mgmt_pkg::FRAME_LAST - next_n)];
            d.mdio_oe = !(q.is_read && next_n >= mgmt_pkg::TA_FIRST);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q       <= '0;
      q.state <= HS_IDLE;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign link.mdc          = q.mdc;
  assign link.host_mdio_o  = q.mdio_o;
  assign link.host_mdio_oe = q.mdio_oe;
  assign busy_o            = q.state;
  assign done_o            = q.done;
  assign rd_data_o         = q.rd_data;

endmodule
`default_nettype wire

// ==== logic/mgmt_if.sv ====
// two-wire management link between controller and device
`timescale 1ns/10ps
`default_nettype none
interface mgmt_if;
  logic mdc;
  logic host_mdio_o;
  logic host_mdio_oe;
  logic dev_mdio_o;
  logic dev_mdio_oe;
  logic mdio;

  // shared line with pull-up
  assign mdio = dev_mdio_oe  ? dev_mdio_o  :
                host_mdio_oe ? host_mdio_o : 1'b1;

  modport device (input mdc, input mdio,
                  output dev_mdio_o, output dev_mdio_oe);
  modport host   (output mdc, output host_mdio_o, output host_mdio_oe,
                  input mdio);
endinterface
`default_nettype wire

// ==== logic/mgmt_pkg.sv ====
// constants and helpers shared by both ends of the management serial link
package mgmt_pkg;

  localparam int           CLK_PERIOD_NS  = 20;
  localparam int           LINK_PERIOD_NS = 160;
  localparam logic [3:0]   MDC_HALF       =
    4'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));

  localparam logic [5:0]   PREAMBLE_LEN   = 6'h20;
  localparam logic [1:0]   OP_READ        = 2'h2;
  localparam logic [1:0]   OP_WRITE       = 2'h1;
  localparam logic [1:0]   START_CODE     = 2'h1;
  localparam logic [1:0]   TA_WRITE       = 2'h2;
  localparam logic [3:0]   ADDR_BITS_LAST = 4'h9;
  localparam logic [3:0]   DATA_BITS_LAST = 4'hF;
  localparam logic [15:0]  ABSENT_VALUE   = 16'hFFFF;

  localparam logic [6:0]   FRAME_LAST     = 7'h3F;
  localparam logic [6:0]   NO_PRE_FIRST   = 7'h20;
  localparam logic [6:0]   TA_FIRST       = 7'h2E;
  localparam logic [6:0]   DATA_FIRST     = 7'h30;

  localparam logic [4:0]   REG_BASIC_CONTROL    = 5'h00;
  localparam logic [4:0]   REG_BASIC_STATUS     = 5'h01;
  localparam logic [4:0]   REG_IDENTIFIER_HIGH  = 5'h02;
  localparam logic [4:0]   REG_IDENTIFIER_LOW   = 5'h03;
  localparam logic [4:0]   REG_NEG_ADVERTISE    = 5'h04;
  localparam logic [4:0]   REG_PARTNER_ABILITY  = 5'h05;
  localparam logic [4:0]   REG_NEG_EXPANSION    = 5'h06;
  localparam logic [4:0]   REG_NEXT_PAGE_TX     = 5'h07;
  localparam logic [4:0]   REG_PARTNER_NEXT     = 5'h08;
  localparam logic [4:0]   REG_EXTENDED_CONTROL = 5'h10;
  localparam logic [4:0]   REG_DETAILED_STATUS  = 5'h11;
  localparam logic [4:0]   REG_TEN_MBIT_OPS     = 5'h12;
  localparam logic [4:0]   REG_EXT_CONTROL_TWO  = 5'h13;

  localparam int           SKIP_BIT       = 6;
  localparam int           UNLOCK_BIT     = 15;
  localparam int           STATION_LSB    = 6;
  localparam int           STATION_MSB    = 10;

  // identifier values are arbitrary
  localparam logic [15:0]  ID_HIGH_VALUE  = 16'h1234;
  localparam logic [15:0]  ID_LOW_VALUE   = 16'h5678;
  localparam logic [15:0]  EXT_CTRL_RESET = 16'h0040;

  function automatic logic is_present(input logic [4:0] a);
    return (a <= REG_PARTNER_NEXT) ||
           (a >= REG_EXTENDED_CONTROL && a <= REG_EXT_CONTROL_TWO);
  endfunction

  function automatic logic [15:0] reset_value(input logic [4:0] a);
    unique case (a)
      REG_IDENTIFIER_HIGH:  return ID_HIGH_VALUE;
      REG_IDENTIFIER_LOW:   return ID_LOW_VALUE;
      REG_EXTENDED_CONTROL: return EXT_CTRL_RESET;
      default:              return 16'h0000;
    endcase
  endfunction

  // bits software may always write
  function automatic logic [15:0] plain_mask(input logic [4:0] a);
    unique case (a)
      REG_BASIC_CONTROL, REG_NEG_ADVERTISE, REG_NEXT_PAGE_TX,
      REG_EXTENDED_CONTROL, REG_TEN_MBIT_OPS, REG_EXT_CONTROL_TWO:
        return 16'hFFFF;
      default:
        return 16'h0000;
    endcase
  endfunction

  // bits writable only after an unlock write
  function automatic logic [15:0] gated_mask(input logic [4:0] a);
    return (a == REG_BASIC_STATUS) ? 16'h0040 : 16'h0000;
  endfunction

endpackage

// ==== verif/mgmt_link_asserts.sv ====
// concurrent checks on the wires of the management link
`timescale 1ns/10ps
`default_nettype none
module mgmt_link_asserts (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic mdc,
  input wire logic host_mdio_o,
  input wire logic host_mdio_oe,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe,
  input wire logic mdio
);
  localparam int DRIVE_CYCLES = 136;
  logic [7:0] drive_cnt_q;
  logic [7:0] drive_cnt_d;

  // cycles the device has held the line in the current read
  always_comb begin
    drive_cnt_d = dev_mdio_oe ? drive_cnt_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drive_cnt_q <= 8'h00;
    end else begin
      drive_cnt_q <= drive_cnt_d;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence dev_turn_start;
    $rose(dev_mdio_oe) && !dev_mdio_o;
  endsequence
  sequence dev_turn_hold;
    (dev_mdio_oe && !dev_mdio_o) [*6];
  endsequence

  chk_read_turnaround: assert property (
    $rose(dev_mdio_oe) |-> dev_turn_start ##1 dev_turn_hold)
    else $error("device turnaround bit not held low");
  chk_host_released: assert property (
    $rose(dev_mdio_oe) |-> !host_mdio_oe && !$past(host_mdio_oe, 4))
    else $error("device drove before controller let go");
  chk_no_contention: assert property (
    !(dev_mdio_oe && host_mdio_oe))
    else $error("both ends drive the data line");
  chk_mdc_half_period: assert property (
    $changed(mdc) |=> $stable(mdc) [*3])
    else $error("management clock half period too short");
  chk_dev_steady_rise: assert property (
    $rose(mdc) && dev_mdio_oe |->
      $stable(dev_mdio_o) && $past(dev_mdio_o, 2) == dev_mdio_o)
    else $error("device data not settled at clock rise");
  chk_host_fall_change: assert property (
    host_mdio_oe && $changed(host_mdio_o) |-> !mdc)
    else $error("controller changed data while clock high");
  chk_drive_length: assert property (
    $fell(dev_mdio_oe) |-> drive_cnt_q == 8'(DRIVE_CYCLES))
    else $error("device drive window is not seventeen bits");
  chk_frame_start_low: assert property (
    $rose(host_mdio_oe) |-> !mdc && !dev_mdio_oe)
    else $error("frame started with clock high or line busy");

  chk_line_pulled_up: assert property (
    !dev_mdio_oe && !host_mdio_oe |-> mdio)
    else $error("released data line not read as one");
  chk_line_follows_dev: assert property (
    dev_mdio_oe |-> mdio == dev_mdio_o)
    else $error("data line does not carry the device bit");

  cov_read_drive: cover property ($fell(dev_mdio_oe));
endmodule
`default_nettype wire

// ==== verif/phy_serial_mgmt_frame_slave_tb.sv ====
// self-checking bench joining controller and device ends
`timescale 1ns/10ps
`default_nettype none
module phy_serial_mgmt_frame_slave_tb;
  logic        clock_i;
  logic        reset_n_i;
  logic        req_i;
  logic        req_write_i;
  logic        req_preamble_i;
  logic [4:0]  req_station_i;
  logic [4:0]  req_reg_i;
  logic [15:0] req_data_i;
  logic [15:0] status_i;
  logic        done_o;
  logic        busy_o;
  logic        req_bad_op_i;
  logic        bad_op;
  logic [15:0] rd_data_o;
  logic [15:0] basic_control_o;
  logic [15:0] extended_control_o;
  logic        preamble_skip_o;
  logic        write_strobe_o;
  logic [4:0]  write_addr_o;
  logic [15:0] write_data_o;
  logic [15:0] mreg [32];
  logic        unlock_m;
  logic        skip_m;
  logic [4:0]  exp_waddr;
  logic [15:0] exp_wdata;
  int          n_errors;
  int          comparisons;
  int          n_strobes = 0;
  int          exp_strobes;

  mgmt_if mgmt_if_i ();
  mgmt_host mgmt_host_i (.clock_i, .reset_n_i, .clk_en_i(1'b1),
    .link(mgmt_if_i), .req_i, .req_write_i, .req_preamble_i,
    .req_bad_op_i, .req_station_i, .req_reg_i, .req_data_i, .busy_o,
    .done_o,
    .rd_data_o);
  mgmt_device mgmt_device_i (.clock_i, .reset_n_i, .clk_en_i(1'b1),
    .link(mgmt_if_i), .status_i, .basic_control_o, .extended_control_o,
    .preamble_skip_o, .write_strobe_o, .write_addr_o, .write_data_o);
  mgmt_link_asserts mgmt_link_asserts_i (.clock_i, .reset_n_i,
    .mdc(mgmt_if_i.mdc), .host_mdio_o(mgmt_if_i.host_mdio_o),
    .host_mdio_oe(mgmt_if_i.host_mdio_oe),
    .dev_mdio_o(mgmt_if_i.dev_mdio_o),
    .dev_mdio_oe(mgmt_if_i.dev_mdio_oe), .mdio(mgmt_if_i.mdio));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  always @(negedge clock_i) begin
    if (write_strobe_o === 1'b1) begin
      n_strobes++;
    end
  end

  function automatic logic present(input logic [4:0] a);
    return (a <= 5'h08) || (a >= 5'h10 && a <= 5'h13);
  endfunction

  function automatic logic [15:0] wmask(input logic [4:0] a);
    case (a)
      5'h00, 5'h04, 5'h07, 5'h10, 5'h12, 5'h13: return 16'hFFFF;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one whole frame through the controller, model updated alongside
  task automatic frame(input logic w, input logic p, input logic [4:0] st,
                       input logic [4:0] ra, input logic [15:0] d,
                       input logic gap);
    logic [15:0] exp;
    logic [15:0] s;
    logic        acc;
    logic        parsed;
    int          k;
    s = 16'($urandom);
    parsed = p || skip_m;
    acc = parsed && !bad_op && st == mreg[16][10:6];
    exp = !acc ? 16'hFFFF : ra == 5'h01 ? {s[15:7], skip_m, s[5:0]} :
          present(ra) ? mreg[ra] : 16'hFFFF;
    if (parsed) begin
      exp_waddr = ra;
    end
    if (w && acc) begin
      exp_wdata = d;
    end
    if (w && acc && present(ra)) begin
      exp_strobes++;
      if (ra == 5'h10) begin
        mreg[16] = {1'b0, d[14:0]};
        unlock_m = d[15];
      end else begin
        mreg[ra] = (mreg[ra] & ~wmask(ra)) | (d & wmask(ra));
        if (ra == 5'h01 && unlock_m) begin
          skip_m = d[6];
        end
        unlock_m = 1'b0;
      end
    end
    @(posedge clock_i);
    req_i          <= 1'b1;
    req_write_i    <= w;
    req_preamble_i <= p;
    req_station_i  <= st;
    req_reg_i      <= ra;
    req_data_i     <= d;
    status_i       <= s;
    req_bad_op_i   <= bad_op;
    @(posedge clock_i);
    req_i <= 1'b0;
    @(negedge clock_i);
    check("busy_o", 16'h0001, 16'(busy_o));
    for (k = 0; k < 600 && done_o !== 1'b1; k++) begin
      @(negedge clock_i);
    end
    if (k == 600) begin
      n_errors++;
      $display("[ERR] done_o expected 1 seen 0");
      tally_and_finish();
    end
    check("busy_o", 16'h0000, 16'(busy_o));
    if (!w) begin
      check("rd_data_o", exp, rd_data_o);
    end
    if (gap) begin
      repeat (8) @(negedge clock_i);
      check("strobes", 16'(exp_strobes), 16'(n_strobes));
      check("basic_control_o", mreg[0], basic_control_o);
      check("extended_control_o", mreg[16], extended_control_o);
      check("preamble_skip_o", 16'(skip_m), 16'(preamble_skip_o));
      check("write_addr_o", 16'(exp_waddr), 16'(write_addr_o));
      check("write_data_o", exp_wdata, write_data_o);
    end
  endtask

  initial begin
    int          i;
    logic [4:0]  st;
    reset_n_i = 1'b0;
    req_i = 1'b0;
    req_write_i = 1'b0;
    req_preamble_i = 1'b0;
    req_station_i = 5'h00;
    req_reg_i = 5'h00;
    req_data_i = 16'h0000;
    status_i = 16'h0000;
    req_bad_op_i = 1'b0;
    bad_op = 1'b0;
    n_errors = 0;
    comparisons = 0;
    exp_strobes = 0;
    for (i = 0; i < 32; i++) begin
      mreg[i] = 16'h0000;
    end
    mreg[2] = mgmt_pkg::ID_HIGH_VALUE;
    mreg[3] = mgmt_pkg::ID_LOW_VALUE;
    mreg[16] = mgmt_pkg::EXT_CTRL_RESET;
    unlock_m = 1'b0;
    skip_m = 1'b0;
    exp_waddr = 5'h00;
    exp_wdata = 16'h0000;
    void'($urandom(60));
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    // reset values, absent places read as ones
    for (i = 0; i < 32; i++) begin
      frame(1'b0, 1'b1, 5'h01, 5'(i), 16'h0000, i == 0);
    end
    // every place written, station kept, skip locked
    for (i = 0; i < 32; i++) begin
      frame(1'b1, 1'b1, 5'h01, 5'(i),
            i == 16 ? 16'h0040 : 16'($urandom), 1'b1);
    end
    // read back with no spacing between frames
    for (i = 0; i < 32; i++) begin
      frame(1'b0, 1'b1, 5'h01, 5'(i), 16'h0000, 1'b0);
    end
    frame(1'b1, 1'b1, 5'h02, 5'h00, 16'hA5A5, 1'b1);
    frame(1'b0, 1'b1, 5'h02, 5'h00, 16'h0000, 1'b0);
    frame(1'b1, 1'b0, 5'h01, 5'h00, 16'h5A5A, 1'b1);
    frame(1'b0, 1'b0, 5'h01, 5'h00, 16'h0000, 1'b0);
    frame(1'b1, 1'b1, 5'h01, 5'h10, 16'h8040, 1'b1);
    frame(1'b1, 1'b1, 5'h01, 5'h01, 16'h0040, 1'b1);
    frame(1'b1, 1'b1, 5'h01, 5'h01, 16'h0000, 1'b1);
    // opcodes 00 and 11 must be ignored
    bad_op = 1'b1;
    frame(1'b1, 1'b1, 5'h01, 5'h00, 16'hFFFF, 1'b1);
    frame(1'b0, 1'b1, 5'h01, 5'h02, 16'h0000, 1'b0);
    bad_op = 1'b0;
    for (i = 0; i < 8; i++) begin
      frame(1'($urandom), 1'b0, 5'h01, 5'($urandom), 16'($urandom),
            1'b0);
    end
    frame(1'b1, 1'b0, 5'h01, 5'h10, 16'h02C0, 1'b1);
    frame(1'b0, 1'b0, 5'h0B, 5'h10, 16'h0000, 1'b0);
    frame(1'b0, 1'b0, 5'h01, 5'h00, 16'h0000, 1'b1);
    for (i = 0; i < 60; i++) begin
      st = ($urandom % 4 == 0) ? 5'($urandom) : mreg[16][10:6];
      frame(1'($urandom), 1'($urandom), st,
            5'($urandom), 16'($urandom), 1'($urandom));
    end
    frame(1'b0, 1'b1, mreg[16][10:6], 5'h00, 16'h0000, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
